/* design/serial_report_pkg.sv */
// Shared constants, types and helpers of the serial report link
package serial_report_pkg;
  // System clock
  localparam int CLK_HZ = 40_000_000;

  // Bit periods in clock cycles, one per baud rate
  localparam logic [16:0] DIV_9600  = 17'(CLK_HZ / 9600);
  localparam logic [16:0] DIV_4800  = 17'(CLK_HZ / 4800);
  localparam logic [16:0] DIV_2400  = 17'(CLK_HZ / 2400);
  localparam logic [16:0] DIV_1200  = 17'(CLK_HZ / 1200);
  localparam logic [16:0] DIV_600   = 17'(CLK_HZ / 600);
  localparam logic [16:0] DIV_19200 = 17'(CLK_HZ / 19200);
  localparam logic [16:0] DIV_38400 = 17'(CLK_HZ / 38400);

  // Receive silence before returning to push mode
  localparam int SILENCE_S   = 20;
  localparam int SILENCE_CYC = SILENCE_S * CLK_HZ;
  // Push cycle timer resolution, one hundredth of a second
  localparam int TICK_MS  = 10;
  localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_MS;

  // Setting defaults and limits
  localparam logic [7:0] ADDR_DEF   = 8'h11;
  localparam logic [7:0] ADDR_MAX   = 8'h99;
  localparam logic [2:0] BAUD_DEF   = 3'h0;
  localparam logic [3:0] FMT_DEF    = 4'h0;
  localparam logic       LAYOUT_DEF = 1'b0;
  localparam logic [9:0] CYCLE_DEF  = 10'h000;
  localparam logic [9:0] CYCLE_MAX  = 10'h3e7;
  localparam logic [4:0] SRC_DEF    = 5'h08;
  localparam int         SRC_NUM    = 20;

  // Report characters and positions within a report
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [3:0] IDX_TENS  = 4'h0;
  localparam logic [3:0] IDX_UNITS = 4'h1;
  localparam logic [3:0] IDX_SIGN  = 4'h2;
  localparam logic [3:0] IDX_LF    = 4'h9;
  localparam logic [3:0] IDX_CR    = 4'ha;

  // Character format: data width, parity and stop bits
  typedef struct packed {
    logic eight;
    logic par_en;
    logic par_odd;
    logic two_stop;
  } fmt_s;

  // One reportable value: sign and six decimal digits, most significant first
  typedef struct packed {
    logic            neg;
    logic [5:0][3:0] digit;
  } value_s;

  // Baud select to bit period
  function automatic logic [16:0] baud_div(input logic [2:0] sel);
    unique case (sel)
      3'h0:    return DIV_9600;
      3'h1:    return DIV_4800;
      3'h2:    return DIV_2400;
      3'h3:    return DIV_1200;
      3'h4:    return DIV_600;
      3'h5:    return DIV_19200;
      3'h6:    return DIV_38400;
      default: return DIV_9600;
    endcase
  endfunction : baud_div

  // Format select to framing fields
  function automatic fmt_s fmt_decode(input logic [3:0] sel);
    unique case (sel)
      4'h0:    return '{1'b0, 1'b1, 1'b0, 1'b0};
      4'h1:    return '{1'b0, 1'b1, 1'b0, 1'b1};
      4'h2:    return '{1'b0, 1'b1, 1'b1, 1'b0};
      4'h3:    return '{1'b0, 1'b1, 1'b1, 1'b1};
      4'h4:    return '{1'b0, 1'b0, 1'b0, 1'b0};
      4'h5:    return '{1'b0, 1'b0, 1'b0, 1'b1};
      4'h6:    return '{1'b1, 1'b1, 1'b0, 1'b0};
      4'h7:    return '{1'b1, 1'b1, 1'b1, 1'b0};
      4'h8:    return '{1'b1, 1'b0, 1'b0, 1'b0};
      4'h9:    return '{1'b1, 1'b0, 1'b0, 1'b1};
      default: return '{1'b0, 1'b1, 1'b0, 1'b0};
    endcase
  endfunction : fmt_decode

  // Parity bit over the used data bits
  function automatic logic parity_bit(input logic [7:0] data, input fmt_s fmt);
    return (^(data & {fmt.eight, 7'h7f})) ^ fmt.par_odd;
  endfunction : parity_bit
endpackage : serial_report_pkg

/* design/report_uart_tx.sv */
// Character transmitter with selectable framing
`timescale 1ns/100ps
`default_nettype none
module report_uart_tx (
  input  wire logic                          clk_i,   // System clock
  input  wire logic                          srst_i,  // Sync reset
  input  wire logic                          en_i,    // Clock enable
  input  wire logic [16:0]                   div_i,   // Bit period
  input  wire serial_report_pkg::fmt_s       fmt_i,   // Framing
  input  wire logic [7:0]                    data_i,  // Character
  input  wire logic                          valid_i, // Character offered
  output logic                               ready_o, // Idle, takes character
  output logic                               txd_o    // Serial line
);
  logic [11:0] frame_w;
  logic [3:0]  nbits_w;
  logic [11:0] shift_q;
  logic [3:0]  left_q;
  logic [16:0] cnt_q;
  logic [16:0] div_q;

  // Start bit, data LSB first, parity, stop bits
  always_comb
  begin
    frame_w = 12'hfff;
    frame_w[0] = 1'b0;                                              // [R14]
    frame_w[7:1] = data_i[6:0];
    if (fmt_i.eight)
      frame_w[8] = data_i[7];
    if (fmt_i.par_en)
      frame_w[fmt_i.eight ? 9 : 8] = serial_report_pkg::parity_bit(data_i, fmt_i);
    nbits_w = 4'h9 + {3'h0, fmt_i.eight} + {3'h0, fmt_i.par_en} + {3'h0, fmt_i.two_stop};
  end

  assign ready_o = (left_q == 4'h0);

  // Shift one bit per bit period
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      shift_q <= 12'hfff;
      left_q  <= 4'h0;
      cnt_q   <= 17'h00000;
      div_q   <= serial_report_pkg::DIV_9600;
      txd_o   <= 1'b1;
    end
    else if (en_i)
    begin
      if (ready_o && valid_i)
      begin
        shift_q <= {1'b1, frame_w[11:1]};
        txd_o   <= frame_w[0];
        left_q  <= nbits_w;
        div_q   <= div_i;
        cnt_q   <= 17'h00000;
      end
      else if (!ready_o)
      begin
        if (cnt_q == div_q - 17'h00001)
        begin
          cnt_q   <= 17'h00000;
          left_q  <= left_q - 4'h1;
          txd_o   <= (left_q == 4'h1) ? 1'b1 : shift_q[0];
          shift_q <= {1'b1, shift_q[11:1]};
        end
        else
          cnt_q <= cnt_q + 17'h00001;
      end
    end
  end
endmodule : report_uart_tx
`default_nettype wire

/* design/report_uart_rx.sv */
// Character receiver with input synchroniser and selectable framing
`timescale 1ns/100ps
`default_nettype none
module report_uart_rx (
  input  wire logic                    clk_i,   // System clock
  input  wire logic                    srst_i,  // Sync reset
  input  wire logic                    en_i,    // Clock enable
  input  wire logic                    rxd_i,   // Serial line, async
  input  wire logic [16:0]             div_i,   // Bit period
  input  wire serial_report_pkg::fmt_s fmt_i,   // Framing
  output logic [7:0]                   data_o,  // Received character
  output logic                         valid_o, // Character pulse
  output logic                         error_o  // Parity or stop fault pulse
);
  logic [2:0]  sync_q;
  logic        line_q;
  logic        busy_q;
  logic [16:0] cnt_q;
  logic [3:0]  idx_q;
  logic [10:0] bits_q;
  logic [3:0]  last_w;
  logic [7:0]  data_w;
  logic        par_w;
  logic        bad_w;

  // Index of first stop bit and the character seen
  assign last_w = 4'h8 + {3'h0, fmt_i.eight} + {3'h0, fmt_i.par_en};
  assign data_w = fmt_i.eight ? bits_q[7:0] : {1'b0, bits_q[6:0]};
  assign par_w  = fmt_i.eight ? bits_q[8] : bits_q[7];
  assign bad_w  = !line_q ||
                  (fmt_i.par_en && par_w != serial_report_pkg::parity_bit(data_w, fmt_i));

  // Mid-bit sampling; one stop bit checked
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync_q  <= 3'h7;
      line_q  <= 1'b1;
      busy_q  <= 1'b0;
      cnt_q   <= 17'h00000;
      idx_q   <= 4'h0;
      bits_q  <= 11'h000;
      data_o  <= 8'h00;
      valid_o <= 1'b0;
      error_o <= 1'b0;
    end
    else if (en_i)
    begin
      sync_q  <= {sync_q[1:0], rxd_i};
      valid_o <= 1'b0;
      error_o <= 1'b0;
      if (sync_q[1] == sync_q[2])
        line_q <= sync_q[2];
      if (!busy_q)
      begin
        if (!line_q)
        begin
          busy_q <= 1'b1;
          idx_q  <= 4'h0;
          cnt_q  <= {1'b0, div_i[16:1]};
        end
      end
      else if (cnt_q == div_i - 17'h00001)
      begin
        cnt_q <= 17'h00000;
        idx_q <= idx_q + 4'h1;
        if (idx_q == 4'h0)
          busy_q <= !line_q;
        else if (idx_q == last_w)
        begin
          busy_q  <= 1'b0;
          data_o  <= data_w;
          valid_o <= 1'b1;
          error_o <= bad_w;
        end
        else
          bits_q[idx_q - 4'h1] <= line_q;
      end
      else
        cnt_q <= cnt_q + 17'h00001;
    end
  end
endmodule : report_uart_rx
`default_nettype wire

/* design/serial_report_link.sv */
// Serial reporting port: request/response traffic and cyclic push reports
//
// Overview of operation
// (R1) In request/response mode transmit only replies to received requests.
// (R2) In push mode send report strings unprompted, paced by the cycle timer.
// (R3) Any received character switches immediately to request/response mode.
// (R4) Twenty seconds without characters returns to push mode and cyclic reports.
// (R5) Station address 11 to 99, default 11; addresses with zero digit invalid.
// (R6) Baud select 0..6 maps 9600,4800,2400,1200,600,19200,38400; default 0.
// (R7) Format select 0..9 picks data bits, parity, stop bits; default 0.
// (R8) Layout 0 sends address, data, LF, CR; layout 1 omits address.
// (R9) Data is a sign character then six value characters.
// (R10) Cycle period 0 to 9.99 s; zero disables cyclic reports.
// (R11) Source select 0..19, default 8, picks the register reported.
// (R12) Frequency in 0.1 Hz steps; analog value 10000 means full scale.
// (R13) Silence timer restarts per character and is held clear in push mode.
// (R14) Frames: low start bit, data LSB first, parity, high stop bits.
// (R15) After reset start in push mode with the push timer at zero.
`timescale 1ns/100ps
`default_nettype none
module serial_report_link #(
  parameter int SILENCE_CYC = serial_report_pkg::SILENCE_CYC, // Silence limit in cycles
  parameter int TICK_CYC    = serial_report_pkg::TICK_CYC     // Cycles per 10 ms tick
) (
  input  wire logic                                clk_i,           // System clock, 40 MHz
  input  wire logic                                srst_i,          // Sync reset, active high
  input  wire logic                                en_i,            // Clock enable
  input  wire logic                                rxd_i,           // Serial receive pin
  output logic                                     txd_o,           // Serial transmit pin
  input  wire logic [7:0]                          station_addr_i,  // Address, two BCD digits
  input  wire logic [2:0]                          baud_sel_i,      // Baud rate select
  input  wire logic [3:0]                          fmt_sel_i,       // Character format select
  input  wire logic                                layout_sel_i,    // Push report layout
  input  wire logic [9:0]                          cycle_i,         // Push period, 10 ms units
  input  wire logic [4:0]                          src_sel_i,       // Reported register
  input  wire serial_report_pkg::value_s [19:0]    src_values_i,    // Measurement registers
  output logic [7:0]                               rx_data_o,       // Request character
  output logic                                     rx_valid_o,      // Request character pulse
  output logic                                     rx_error_o,      // Framing or parity fault
  input  wire logic [7:0]                          reply_data_i,    // Reply character
  input  wire logic                                reply_valid_i,   // Reply offered
  output logic                                     reply_ready_o,   // Reply taken
  output logic                                     req_mode_o,      // Request/response mode
  output logic                                     addr_valid_o,    // Address setting legal
  output logic                                     report_busy_o    // Push report in progress
);
  typedef enum logic {
    MODE_PUSH = 1'b0,
    MODE_REQ  = 1'b1
  } mode_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } send_e;

  mode_e                       mode_q;
  send_e                       state_q;
  logic [29:0]                 silence_q;
  logic [18:0]                 tick_q;
  logic [9:0]                  cycle_cnt_q;
  logic                        due_q;
  logic [3:0]                  idx_q;
  serial_report_pkg::value_s   value_q;
  logic [7:0]                  addr_q;

  serial_report_pkg::fmt_s     fmt_w;
  logic [16:0]                 div_w;
  logic [7:0]                  rx_byte_w;
  logic                        rx_stb_w;
  logic                        rx_err_w;
  logic                        tx_ready_w;
  logic                        tx_valid_w;
  logic [7:0]                  tx_data_w;
  logic                        push_w;
  logic                        silence_done_w;
  logic                        tick_w;
  logic                        fire_w;
  logic                        start_w;
  logic                        push_take_w;
  logic                        src_ok_w;
  serial_report_pkg::value_s   src_w;
  logic [3:0]                  digit_w;
  logic [7:0]                  char_w;

  // Line settings shared by both directions
  assign div_w = serial_report_pkg::baud_div(baud_sel_i);   // [R6]
  assign fmt_w = serial_report_pkg::fmt_decode(fmt_sel_i);  // [R7]

  // Receiver
  report_uart_rx u_rx (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .en_i    (en_i),
    .rxd_i   (rxd_i),
    .div_i   (div_w),
    .fmt_i   (fmt_w),
    .data_o  (rx_byte_w),
    .valid_o (rx_stb_w),
    .error_o (rx_err_w)
  );

  // Transmitter
  report_uart_tx u_tx (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .en_i    (en_i),
    .div_i   (div_w),
    .fmt_i   (fmt_w),
    .data_i  (tx_data_w),
    .valid_i (tx_valid_w),
    .ready_o (tx_ready_w),
    .txd_o   (txd_o)
  );

  // Request characters pass straight on to the protocol handler
  assign rx_data_o  = rx_byte_w;
  assign rx_valid_o = rx_stb_w;
  assign rx_error_o = rx_err_w;

  // Mode and timer conditions
  assign push_w         = (mode_q == MODE_PUSH);
  assign req_mode_o     = !push_w;
  assign silence_done_w = (silence_q == 30'(SILENCE_CYC - 1));
  assign tick_w         = (tick_q == 19'(TICK_CYC - 1));
  assign fire_w         = tick_w && (cycle_i != 10'h000) &&
                          (cycle_cnt_q >= cycle_i - 10'h001);          // [R10]

  // Address legality: two nonzero decimal digits
  assign addr_valid_o = (station_addr_i[7:4] != 4'h0) && (station_addr_i[7:4] <= 4'h9) &&
                        (station_addr_i[3:0] != 4'h0) && (station_addr_i[3:0] <= 4'h9); // [R5]

  // Request/response vs push mode
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      mode_q <= MODE_PUSH;                                             // [R15]
    else if (en_i)
    begin
      if (rx_stb_w)
        mode_q <= MODE_REQ;                                            // [R3]
      else if (!push_w && silence_done_w)
        mode_q <= MODE_PUSH;                                           // [R4]
    end
  end

  // Receive silence timer
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      silence_q <= 30'h00000000;
    else if (en_i)
    begin
      if (push_w || rx_stb_w)
        silence_q <= 30'h00000000;                                     // [R13]
      else if (!silence_done_w)
        silence_q <= silence_q + 30'h00000001;                         // [R4]
    end
  end

  // Push cycle timer in 10 ms ticks
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tick_q      <= 19'h00000;                                        // [R15]
      cycle_cnt_q <= 10'h000;
    end
    else if (en_i)
    begin
      if (!push_w)
      begin
        tick_q      <= 19'h00000;
        cycle_cnt_q <= 10'h000;
      end
      else if (tick_w)
      begin
        tick_q      <= 19'h00000;
        cycle_cnt_q <= fire_w ? 10'h000 : cycle_cnt_q + 10'h001;
      end
      else
        tick_q <= tick_q + 19'h00001;
    end
  end

  // Pending report; a new period event wins over its consumption
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      due_q <= 1'b0;
    else if (en_i)
    begin
      if (!push_w || rx_stb_w)
        due_q <= 1'b0;
      else if (fire_w && push_w)
        due_q <= 1'b1;                                                 // [R2]
      else if (start_w)
        due_q <= 1'b0;
    end
  end

  // Source selection and snapshot
  assign src_ok_w = (src_sel_i < 5'(serial_report_pkg::SRC_NUM));    // [R11]
  assign src_w    = src_ok_w ? src_values_i[src_sel_i] : '0;          // [R12]
  assign start_w  = (state_q == ST_IDLE) && due_q && push_w && !rx_stb_w;

  // Report character at the current position
  assign digit_w = value_q.digit[4'(serial_report_pkg::IDX_LF - 4'h1 - idx_q)];
  assign char_w  = (idx_q == serial_report_pkg::IDX_TENS)  ? {4'h3, addr_q[7:4]} :
                   (idx_q == serial_report_pkg::IDX_UNITS) ? {4'h3, addr_q[3:0]} :
                   (idx_q == serial_report_pkg::IDX_SIGN)  ?
                     (value_q.neg ? serial_report_pkg::CH_MINUS : serial_report_pkg::CH_PLUS) :
                   (idx_q == serial_report_pkg::IDX_LF)    ? serial_report_pkg::CH_LF :
                   (idx_q == serial_report_pkg::IDX_CR)    ? serial_report_pkg::CH_CR :
                     (serial_report_pkg::CH_ZERO | {4'h0, digit_w});   // [R9]

  // Transmit arbitration: reports in push mode, replies only in request mode
  assign push_take_w   = (state_q == ST_SEND) && push_w && !rx_stb_w;
  assign tx_valid_w    = push_take_w || (!push_w && reply_valid_i);    // [R1]
  assign tx_data_w     = push_take_w ? char_w : reply_data_i;
  assign reply_ready_o = !push_w && tx_ready_w && (state_q == ST_IDLE);// [R1]
  assign report_busy_o = (state_q == ST_SEND);

  // Report sequencer
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_q <= ST_IDLE;
      idx_q   <= serial_report_pkg::IDX_TENS;
      value_q <= '0;
      addr_q  <= serial_report_pkg::ADDR_DEF;
    end
    else if (en_i)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (start_w)
          begin
            state_q <= ST_SEND;                                        // [R2]
            value_q <= src_w;                                          // [R11]
            addr_q  <= station_addr_i;
            idx_q   <= layout_sel_i ? serial_report_pkg::IDX_SIGN
                                    : serial_report_pkg::IDX_TENS;     // [R8]
          end
        end
        ST_SEND:
        begin
          if (!push_w || rx_stb_w)
            state_q <= ST_IDLE;                                        // [R3]
          else if (tx_ready_w)
          begin
            if (idx_q == serial_report_pkg::IDX_CR)
              state_q <= ST_IDLE;                                      // [R8]
            else
              idx_q <= idx_q + 4'h1;
          end
        end
      endcase
    end
  end
endmodule : serial_report_link
`default_nettype wire

/* testbench/serial_report_link_checker.sv */
// Port-level checks of the serial report link
`timescale 1ns/100ps
`default_nettype none
module serial_report_link_checker #(
  parameter int SILENCE_CYC = 2000 // Silence limit in cycles
) (
  input wire logic       clk_i,          // System clock
  input wire logic       srst_i,         // Sync reset
  input wire logic       en_i,           // Clock enable
  input wire logic       txd_o,          // Transmit line
  input wire logic [7:0] station_addr_i, // Address setting
  input wire logic [9:0] cycle_i,        // Push period
  input wire logic       rx_valid_o,     // Character pulse
  input wire logic       rx_error_o,     // Fault pulse
  input wire logic       reply_valid_i,  // Reply offered
  input wire logic       reply_ready_o,  // Reply taken
  input wire logic       req_mode_o,     // Request mode
  input wire logic       addr_valid_o,   // Address legal
  input wire logic       report_busy_o   // Report running
);
  logic [31:0] sil_q;
  logic        addr_ok_w;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Both address digits within 1 to 9
  assign addr_ok_w = (station_addr_i[7:4] inside {[4'h1:4'h9]}) && (station_addr_i[3:0] inside {[4'h1:4'h9]});
  // Silent cycles in request mode
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !req_mode_o || rx_valid_o)
      sil_q <= '0;
    else if (en_i)
      sil_q <= sil_q + 32'h1;
  end
  a_push_no_reply: assert property (!req_mode_o |-> !reply_ready_o)
    else $error("reply accepted outside request mode");
  a_reply_launch: assert property (en_i && reply_valid_i && reply_ready_o |=> !txd_o && !reply_ready_o)
    else $error("reply did not start its frame");
  a_report_push_only: assert property ($rose(report_busy_o) |-> !req_mode_o)
    else $error("push report began in request mode");
  a_rx_enters_req: assert property (rx_valid_o && en_i |=> req_mode_o)
    else $error("character did not select request mode");
  a_req_stops_push: assert property ($rose(req_mode_o) |-> ##[0:2] !report_busy_o)
    else $error("push report kept running in request mode");
  a_silence_bound: assert property (req_mode_o |-> sil_q <= SILENCE_CYC + 2)
    else $error("request mode outlived the silence limit");
  a_silence_early: assert property ($fell(req_mode_o) |-> sil_q + 32'h3 >= SILENCE_CYC)
    else $error("request mode left before the silence limit");
  a_addr_flag: assert property (addr_valid_o == addr_ok_w)
    else $error("address legality flag wrong");
  a_reset_idle: assert property (disable iff (1'b0) srst_i |=> txd_o && !req_mode_o && !report_busy_o)
    else $error("state after reset not idle push mode");
  a_err_with_valid: assert property (rx_error_o |-> rx_valid_o)
    else $error("receive fault without character pulse");
  a_push_start_bit: assert property ($rose(report_busy_o) |-> ##[0:2] !txd_o)
    else $error("push report without start bit");
  a_zero_cycle_idle: assert property (cycle_i == 10'h000 && !report_busy_o |=> !report_busy_o)
    else $error("push report with cycle disabled");
  c_push_report: cover property ($rose(report_busy_o));
  c_mode_return: cover property ($fell(req_mode_o));
  c_reply_taken: cover property (reply_valid_i && reply_ready_o);
endmodule : serial_report_link_checker
bind serial_report_link serial_report_link_checker #(.SILENCE_CYC(SILENCE_CYC)) chk_u (.*);
`default_nettype wire

/* testbench/host_model.sv */
// Host on the serial line: sends and decodes 7E1 characters at 38400 baud
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic clk_i, // System clock
  input  wire logic txd_i, // Device transmit line
  output var logic  rxd_o  // Device receive line
);
  localparam int DIV = int'(serial_report_pkg::DIV_38400);
  // Line rests at mark level between frames
  initial rxd_o = 1'b1;
  // Start, seven data bits LSB first, even parity, one stop
  task automatic send(input logic [7:0] ch);
    logic [9:0] f;
    int         i;
    f = {1'b1, ^ch[6:0], ch[6:0], 1'b0};
    for (i = 0; i < 10; i++)
    begin
      @(negedge clk_i);
      rxd_o = f[i];
      repeat (DIV - 1) @(negedge clk_i);
    end
  endtask : send
  // Frame bits in line order, sampled mid-bit
  task automatic recv(output logic [9:0] f, output bit ok);
    int n;
    ok = 1'b0;
    f = '0;
    for (n = 0; n < 20 * DIV && txd_i; n++)
      @(negedge clk_i);
    if (txd_i)
      return;
    repeat (DIV / 2) @(negedge clk_i);
    for (n = 0; n < 10; n++)
    begin
      f[n] = txd_i;
      if (n < 9)
        repeat (DIV) @(negedge clk_i);
    end
    ok = 1'b1;
  endtask : recv
endmodule : host_model
`default_nettype wire

/* testbench/tb_top.sv */
// Bench: push reports, mode switching, replies
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int SIL = 12000;
  localparam int DIV = int'(serial_report_pkg::DIV_38400);
  logic                              clk_i = 1'b0;
  logic                              srst_i = 1'b1;
  logic                              en_i = 1'b1;
  logic [2:0]                        baud_sel_i = 3'h6;
  logic [3:0]                        fmt_sel_i = 4'h0;
  wire logic                         rxd_i;
  logic                              txd_o, rx_valid_o, rx_error_o, reply_ready_o;
  logic                              req_mode_o, addr_valid_o, report_busy_o;
  logic [7:0]                        station_addr_i = 8'h37;
  logic [7:0]                        rx_data_o;
  logic [7:0]                        reply_data_i = 8'h52;
  logic [9:0]                        cycle_i = 10'h000;
  logic [4:0]                        src_sel_i = 5'h09;
  logic                              layout_sel_i = 1'b0;
  logic                              reply_valid_i = 1'b0;
  serial_report_pkg::value_s [19:0]  src_values_i;
  int                                miscompares = 0;
  int                                tests_run = 0;
  // Free-running 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  serial_report_link #(.SILENCE_CYC(SIL), .TICK_CYC(100)) dut_u (.*);
  host_model host_u (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask : check
  // Any receive fault is a mismatch
  always @(negedge clk_i)
    if (rx_error_o)
      check(rx_error_o, 1'b0);
  task automatic results();
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  // Bounded wait for mode (0) or busy (1) to reach a level
  task automatic wait_lvl(input int s, input logic lvl, input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(negedge clk_i);
      if ((s == 0 ? req_mode_o : report_busy_o) === lvl)
        return;
    end
    miscompares++;
    results();
  endtask : wait_lvl
  task automatic expect_char(input logic [7:0] ch);
    logic [9:0] f;
    bit         ok;
    host_u.recv(f, ok);
    if (!ok)
    begin
      miscompares++;
      results();
    end
    check(16'(f), 16'({1'b1, ^ch[6:0], ch[6:0], 1'b0}));
  endtask : expect_char
  task automatic do_reset(input logic [9:0] cyc, input logic lay, input logic [4:0] src);
    @(negedge clk_i);
    srst_i = 1'b1;
    cycle_i = cyc;
    layout_sel_i = lay;
    src_sel_i = src;
    repeat (12) @(negedge clk_i);
    srst_i = 1'b0;
  endtask : do_reset
  // Reset state, disabled cycle, address legality
  task automatic t_defaults();
    logic [7:0] a[6] = '{8'h11, 8'h99, 8'h10, 8'h01, 8'h5a, 8'h37};
    do_reset(10'h000, 1'b0, 5'h08);
    check(txd_o, 1'b1);
    check(req_mode_o, 1'b0);
    repeat (400) @(negedge clk_i);
    check(report_busy_o, 1'b0);
    foreach (a[k])
    begin
      station_addr_i = a[k];
      @(negedge clk_i);
      check(addr_valid_o, a[k][7:4] inside {[1:9]} && a[k][3:0] inside {[1:9]});
    end
  endtask : t_defaults
  // Push report, broken off by a character, resumed after silence
  task automatic t_push();
    do_reset(10'h001, 1'b0, 5'h09);
    wait_lvl(1, 1'b1, 300);
    check(req_mode_o, 1'b0);
    expect_char(8'h33);
    expect_char(8'h37);
    expect_char(8'h2d);
    host_u.send(8'h41);
    wait_lvl(0, 1'b1, DIV);
    check(rx_data_o, 8'h41);
    wait_lvl(1, 1'b0, 5);
    repeat (SIL - DIV) @(negedge clk_i);
    check(req_mode_o, 1'b1);
    wait_lvl(0, 1'b0, DIV);
    wait_lvl(1, 1'b1, 300);
  endtask : t_push
  // Layout without address, other source register
  task automatic t_layout();
    do_reset(10'h001, 1'b1, 5'h07);
    en_i = 1'b0;
    repeat (300) @(negedge clk_i);
    check(report_busy_o, 1'b0);
    en_i = 1'b1;
    wait_lvl(1, 1'b1, 300);
    expect_char(8'h2b);
    expect_char(8'h39);
  endtask : t_layout
  // Reply in request mode while a second character restarts silence
  task automatic t_reply();
    int n;
    do_reset(10'h000, 1'b0, 5'h08);
    host_u.send(8'h41);
    wait_lvl(0, 1'b1, DIV);
    fork
      host_u.send(8'h42);
      expect_char(8'h52);
      begin
        reply_valid_i = 1'b1;
        for (n = 0; n < 100 && reply_ready_o !== 1'b1; n++)
          @(negedge clk_i);
        @(negedge clk_i);
        reply_valid_i = 1'b0;
        check(n < 100, 1'b1);
      end
    join
    repeat (3000) @(negedge clk_i);
    check(req_mode_o, 1'b1);
    check(rx_data_o, 8'h42);
  endtask : t_reply
  initial
  begin
    src_values_i = '0;
    src_values_i[9] = 25'h1123456;
    src_values_i[7] = 25'h0912345;
    t_defaults();
    t_push();
    t_layout();
    t_reply();
    results();
  end
endmodule : tb_top
`default_nettype wire
